// ==== aufz_defs.svh ====
// Register map, field positions, reset values and sizes of the audio queue status block
//
// Overview of operation
// - Shift fetch at frame start with too few words sets tx underflow; write 1 clears.
// - Receive-empty status bit is 1 exactly when the receive queue holds no word.
// - Receive-full status bit is 1 exactly when the receive queue holds sixteen words.
// - Receive threshold flag is high while the receive level exceeds the receive threshold.
// - Receive word into full queue sets overflow and overwrites the oldest entry.
// - Software read of an empty receive queue sets receive underflow; write 1 clears.
// - Three-bit field shows the channel of the word now being transmitted.
// - Transmit and receive interrupt bits are reported; overall flag is their OR.
// - Five-bit receive level field shows words held, zero to sixteen.
// - Five-bit transmit level field shows words held, zero to sixteen.
// - Per channel, sign change or all-zero next sample sets zero-cross flag; W1C.
// - Channels 2-3 need TDM count 1..3, 4-5 need 2..3, 6-7 need 3.
// - In two-channel modes channel 0 is left, channel 1 is right.
// - Reading the receive port returns the oldest word and lowers the receive level.
// - Software write to a full transmit queue sets transmit overflow; write 1 clears.
// - Transmit threshold flag is high while the transmit level is at or below threshold.
// - A channel whose zero-cross flag is set transmits silence.
`ifndef AUFZ_DEFS_SVH
`define AUFZ_DEFS_SVH
`define AUFZ_DEPTH        16
`define AUFZ_WORD_BITS    32
`define AUFZ_OFS_CTRL     8'h20
`define AUFZ_OFS_FLAGS    8'h0c
`define AUFZ_OFS_TXPORT   8'h10
`define AUFZ_OFS_RXPORT   8'h14
`define AUFZ_OFS_LEVELS   8'h24
`define AUFZ_CTRL_RESET   32'h0000_0000
`define AUFZ_CTRL_MASK    32'h0000_07ff
`define AUFZ_CTRL_TX_THRESHOLD_LEVEL    3:0
`define AUFZ_CTRL_RX_THRESHOLD_LEVEL    7:4
`define AUFZ_CTRL_TDM     9:8
`define AUFZ_CTRL_MULTI   10
`define AUFZ_F_TXEMPTY    20
`define AUFZ_F_TXFULL     19
`define AUFZ_F_TXTHR      18
`define AUFZ_F_TXOVER     17
`define AUFZ_F_TXUNDER    16
`define AUFZ_F_RX_QUEUE_EMPTY    12
`define AUFZ_F_RX_QUEUE_FULL     11
`define AUFZ_F_RXTHR      10
`define AUFZ_F_RXOVER     9
`define AUFZ_F_RXUNDER    8
`define AUFZ_F_CHAN       5:3
`define AUFZ_F_TXINT      2
`define AUFZ_F_RXINT      1
`define AUFZ_F_INT        0
`define AUFZ_L_RX_LEVEL      20:16
`define AUFZ_L_TX_LEVEL      12:8
`define AUFZ_L_ZC         7:0
`endif

// ==== aufz_pkg.sv ====
// Types shared by the audio queue status block
package aufz_pkg;
  typedef logic [4:0] aufz_level_t;
  typedef logic [2:0] aufz_chan_t;
  // Sticky event flags, all write-one-to-clear
  typedef struct packed {
    logic tx_underflow_flag;
    logic tx_overflow_flag;
    logic rx_overflow_flag;
    logic rx_underflow_flag;
  } aufz_flags_s;
  // Registered bus address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] ofs;
  } aufz_aphase_s;
endpackage

// ==== aufz_top.sv ====
// Audio transmit/receive queues, status flags, zero-cross flags and serial shifter
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "aufz_defs.svh"
module aufz_top #(
  parameter int DEPTH = `AUFZ_DEPTH
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial audio link
  input  wire logic        bclk_pin,
  input  wire logic        sdi_pin,
  output logic             sdo,
  output logic             frame_sync
);
  localparam int PW = $clog2(DEPTH);

  // Pointers wrap naturally only for a power of two; level field is five bits
  if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("aufz_top: DEPTH must be a power of two from 2 to 16");
  end

  localparam aufz_pkg::aufz_level_t FULL_LVL = aufz_pkg::aufz_level_t'(DEPTH);

  // State
  aufz_pkg::aufz_aphase_s   aph_reg;
  logic [31:0]              ctrl_reg;
  aufz_pkg::aufz_flags_s    flags_reg;
  logic [7:0]               zc_reg;
  logic [7:0]               zc_sign_reg;
  logic [31:0]              tx_mem [DEPTH];
  logic [31:0]              rx_mem [DEPTH];
  logic [PW-1:0]            tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  aufz_pkg::aufz_level_t    tx_level_reg, rx_level_reg;
  logic                     tx_thr_reg, rx_thr_reg;
  aufz_pkg::aufz_chan_t     cur_chan_reg, nxt_chan_reg;
  logic                     bclk_s1_reg, bclk_s2_reg, bclk_s3_reg;
  logic                     sdi_s1_reg, sdi_s2_reg;
  logic [4:0]               tx_bit_reg, rx_bit_reg;
  logic [31:0]              tx_sh_reg, rx_sh_reg;
  logic [31:0]              hrdata_reg;
  logic                     ready_reg;
  logic                     sdo_reg, fsync_reg;

  // Control fields
  logic [3:0]                tx_threshold_level, rx_threshold_level;
  logic [1:0]                tdm_channel_count;
  logic                      pcm_multi;
  aufz_pkg::aufz_chan_t      last_chan;
  aufz_pkg::aufz_level_t     frame_words;
  assign tx_threshold_level = ctrl_reg[`AUFZ_CTRL_TX_THRESHOLD_LEVEL];
  assign rx_threshold_level = ctrl_reg[`AUFZ_CTRL_RX_THRESHOLD_LEVEL];
  assign tdm_channel_count  = ctrl_reg[`AUFZ_CTRL_TDM];
  assign pcm_multi          = ctrl_reg[`AUFZ_CTRL_MULTI];
  // Two channels (left/right) unless multi-channel PCM widens the frame
  assign last_chan   = pcm_multi ? aufz_pkg::aufz_chan_t'({tdm_channel_count, 1'b1}) : 3'h1;
  assign frame_words = aufz_pkg::aufz_level_t'(last_chan) + 5'h01;

  // Bus decode
  logic a_take, w_phase, r_take;
  assign a_take  = hsel && htrans[1] && hready;
  assign r_take  = a_take && !hwrite;
  assign w_phase = aph_reg.valid && aph_reg.write;

  // Link edges; first synchroniser stage feeds only the second
  logic bclk_rise, bclk_fall;
  assign bclk_rise = bclk_s2_reg && !bclk_s3_reg;
  assign bclk_fall = !bclk_s2_reg && bclk_s3_reg;

  // Queue events
  logic tx_push, tx_full_wr, tx_fetch, tx_pop, tx_short, tx_empty;
  logic rx_push, rx_pop, rx_empty_rd, rx_full, rx_empty;
  assign tx_empty   = tx_level_reg == 5'h00;
  assign rx_empty   = rx_level_reg == 5'h00;
  assign rx_full    = rx_level_reg == FULL_LVL;
  assign tx_push    = w_phase && aph_reg.ofs == `AUFZ_OFS_TXPORT && tx_level_reg != FULL_LVL;
  assign tx_full_wr = w_phase && aph_reg.ofs == `AUFZ_OFS_TXPORT && tx_level_reg == FULL_LVL;
  assign tx_fetch   = bclk_fall && tx_bit_reg == 5'h00;
  // Channel 0 takes its word only when all the frame's words are queued
  assign tx_short   = (nxt_chan_reg == 3'h0) ? (tx_level_reg < frame_words) : tx_empty;
  assign tx_pop     = tx_fetch && !tx_short;
  assign rx_push    = bclk_rise && rx_bit_reg == 5'h1f;
  assign rx_pop     = r_take && haddr[7:0] == `AUFZ_OFS_RXPORT && !rx_empty;
  assign rx_empty_rd = r_take && haddr[7:0] == `AUFZ_OFS_RXPORT && rx_empty;

  // Zero-cross detection per channel on each fetched word
  logic [31:0] tx_word;
  logic [7:0]  zc_avail, zc_hit;
  assign tx_word = tx_mem[tx_rp_reg];
  for (genvar c = 0; c < 8; c++) begin : g_zc
    assign zc_avail[c] = (c < 2) || (pcm_multi && tdm_channel_count >= 2'(c / 2));
    assign zc_hit[c]   = tx_pop && nxt_chan_reg == 3'(c) && zc_avail[c] &&
                         (tx_word[31] != zc_sign_reg[c] || tx_word == 32'h0000_0000);
  end

  // Write-one-to-clear strobes
  logic [31:0] w1c_flags, w1c_levels;
  assign w1c_flags  = (w_phase && aph_reg.ofs == `AUFZ_OFS_FLAGS) ? hwdata : 32'h0000_0000;
  assign w1c_levels = (w_phase && aph_reg.ofs == `AUFZ_OFS_LEVELS) ? hwdata : 32'h0000_0000;

  // Interrupt summary bits
  logic tx_irq_pending, rx_irq_pending, any_irq_pending;
  assign tx_irq_pending  = flags_reg.tx_underflow_flag || flags_reg.tx_overflow_flag ||
                           tx_thr_reg;
  assign rx_irq_pending  = flags_reg.rx_underflow_flag || flags_reg.rx_overflow_flag ||
                           rx_thr_reg;
  assign any_irq_pending = tx_irq_pending || rx_irq_pending;

  // Read mux
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      `AUFZ_OFS_CTRL: rd_val = ctrl_reg;
      `AUFZ_OFS_RXPORT: rd_val = rx_empty ? 32'h0000_0000 : rx_mem[rx_rp_reg];
      `AUFZ_OFS_FLAGS: begin
        rd_val[`AUFZ_F_TXEMPTY] = tx_empty;
        rd_val[`AUFZ_F_TXFULL]  = tx_level_reg == FULL_LVL;
        rd_val[`AUFZ_F_TXTHR]   = tx_thr_reg;
        rd_val[`AUFZ_F_TXOVER]  = flags_reg.tx_overflow_flag;
        rd_val[`AUFZ_F_TXUNDER] = flags_reg.tx_underflow_flag;
        rd_val[`AUFZ_F_RX_QUEUE_EMPTY] = rx_empty;
        rd_val[`AUFZ_F_RX_QUEUE_FULL]  = rx_full;
        rd_val[`AUFZ_F_RXTHR]   = rx_thr_reg;
        rd_val[`AUFZ_F_RXOVER]  = flags_reg.rx_overflow_flag;
        rd_val[`AUFZ_F_RXUNDER] = flags_reg.rx_underflow_flag;
        rd_val[`AUFZ_F_CHAN]    = cur_chan_reg;
        rd_val[`AUFZ_F_TXINT]   = tx_irq_pending;
        rd_val[`AUFZ_F_RXINT]   = rx_irq_pending;
        rd_val[`AUFZ_F_INT]     = any_irq_pending;
      end
      `AUFZ_OFS_LEVELS: begin
        rd_val[`AUFZ_L_RX_LEVEL] = rx_level_reg;
        rd_val[`AUFZ_L_TX_LEVEL] = tx_level_reg;
        rd_val[`AUFZ_L_ZC]    = zc_reg;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Address phase capture; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_reg    <= '0;
      hrdata_reg <= 32'h0000_0000;
      ready_reg  <= 1'b0;
    end else begin
      ready_reg     <= 1'b1; // High from the first edge after release
      aph_reg.valid <= a_take;
      aph_reg.write <= hwrite;
      aph_reg.ofs   <= haddr[7:0];
      if (r_take) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // Control register; status registers ignore plain writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `AUFZ_CTRL_RESET;
    end else if (w_phase && aph_reg.ofs == `AUFZ_OFS_CTRL) begin
      ctrl_reg <= hwdata & `AUFZ_CTRL_MASK;
    end
  end

  // Sticky flags: set beats a simultaneous clear so no event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg.tx_underflow_flag <= (tx_fetch && nxt_chan_reg == 3'h0 && tx_short) ||
        (flags_reg.tx_underflow_flag && !w1c_flags[`AUFZ_F_TXUNDER]);
      flags_reg.tx_overflow_flag  <= tx_full_wr ||
        (flags_reg.tx_overflow_flag && !w1c_flags[`AUFZ_F_TXOVER]);
      flags_reg.rx_overflow_flag  <= (rx_push && rx_full) ||
        (flags_reg.rx_overflow_flag && !w1c_flags[`AUFZ_F_RXOVER]);
      flags_reg.rx_underflow_flag <= rx_empty_rd ||
        (flags_reg.rx_underflow_flag && !w1c_flags[`AUFZ_F_RXUNDER]);
    end
  end

  // Zero-cross flags and last seen sign per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zc_reg      <= 8'h00;
      zc_sign_reg <= 8'h00;
    end else begin
      zc_reg <= zc_hit | (zc_reg & ~w1c_levels[`AUFZ_L_ZC]);
      for (int c = 0; c < 8; c++) begin
        if (tx_pop && nxt_chan_reg == 3'(c)) begin
          zc_sign_reg[c] <= tx_word[31];
        end
      end
    end
  end

  // Transmit queue storage
  always_ff @(posedge hclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= hwdata;
    end
  end

  // Transmit queue pointers, level and threshold flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_reg    <= '0;
      tx_rp_reg    <= '0;
      tx_level_reg <= 5'h00;
      tx_thr_reg   <= 1'b1;
    end else begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 1'b1;
      end
      tx_level_reg <= tx_level_reg + 5'(tx_push) - 5'(tx_pop);
      // Follows the level already settled this cycle, one edge behind it
      tx_thr_reg <= tx_level_reg <= 5'(tx_threshold_level);
    end
  end

  // Receive queue storage; a word into a full queue lands on the oldest
  always_ff @(posedge hclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= {rx_sh_reg[30:0], sdi_s2_reg};
    end
  end

  // Receive queue pointers, level and threshold flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_reg    <= '0;
      rx_rp_reg    <= '0;
      rx_level_reg <= 5'h00;
      rx_thr_reg   <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wp_reg <= rx_wp_reg + 1'b1;
      end
      // Overwrite drops the oldest word, so the read side steps past it
      if (rx_pop || (rx_push && rx_full)) begin
        rx_rp_reg <= rx_rp_reg + 1'b1;
      end
      if (!(rx_push && rx_full)) begin
        rx_level_reg <= rx_level_reg + 5'(rx_push) - 5'(rx_pop);
      end else begin
        rx_level_reg <= rx_level_reg - 5'(rx_pop);
      end
      rx_thr_reg <= rx_level_reg > 5'(rx_threshold_level);
    end
  end

  // Link input synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
      bclk_s3_reg <= 1'b0;
      sdi_s1_reg  <= 1'b0;
      sdi_s2_reg  <= 1'b0;
    end else begin
      bclk_s1_reg <= bclk_pin;
      bclk_s2_reg <= bclk_s1_reg;
      bclk_s3_reg <= bclk_s2_reg;
      sdi_s1_reg  <= sdi_pin;
      sdi_s2_reg  <= sdi_s1_reg;
    end
  end

  // Transmit shifter: load a word every 32 falling bit-clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_bit_reg   <= 5'h00;
      tx_sh_reg    <= 32'h0000_0000;
      sdo_reg      <= 1'b0;
      fsync_reg    <= 1'b0;
      cur_chan_reg <= 3'h0;
      nxt_chan_reg <= 3'h0;
    end else if (bclk_fall) begin
      tx_bit_reg <= tx_bit_reg + 5'h01;
      if (tx_fetch) begin
        // Muted channel or missing data sends silence
        if (tx_pop && !zc_reg[nxt_chan_reg]) begin
          sdo_reg   <= tx_word[31];
          tx_sh_reg <= {tx_word[30:0], 1'b0};
        end else begin
          sdo_reg   <= 1'b0;
          tx_sh_reg <= 32'h0000_0000;
        end
        fsync_reg    <= nxt_chan_reg == 3'h0;
        cur_chan_reg <= nxt_chan_reg;
        nxt_chan_reg <= (nxt_chan_reg >= last_chan) ? 3'h0 : nxt_chan_reg + 3'h1;
      end else begin
        sdo_reg   <= tx_sh_reg[31];
        tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
      end
    end
  end

  // Receive shifter: sample on rising bit-clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_bit_reg <= 5'h00;
      rx_sh_reg  <= 32'h0000_0000;
    end else if (bclk_rise) begin
      rx_bit_reg <= rx_bit_reg + 5'h01;
      rx_sh_reg  <= {rx_sh_reg[30:0], sdi_s2_reg};
    end
  end

  // Outputs straight from flops, except hresp tied low
  assign hrdata     = hrdata_reg;
  assign hreadyout  = ready_reg;
  assign hresp      = 1'b0;
  assign sdo        = sdo_reg;
  assign frame_sync = fsync_reg;

endmodule

// ==== aufz_codec.sv ====
// Codec stand-in: makes the bit clock and sends receive words
`timescale 1ns/1ps
module aufz_codec (
  // Serial link toward the block
  output logic      bclk_pin,
  output logic      sdi_pin,
  // Serial link from the block
  input  wire logic sdo,
  input  wire logic frame_sync
);
  logic [31:0] word_q;
  logic [31:0] tx_sh, word_seen;
  logic        sync_seen;
  logic [7:0]  idx;
  int          bitn;
  // Clock rests low between bursts
  initial begin
    bclk_pin = 1'b0;
    sdi_pin  = 1'b1;
    idx      = 8'h00;
    bitn     = 0;
    word_q   = 32'h5a5a5a00;
    tx_sh     = 32'h0000_0000;
    word_seen = 32'h0000_0000;
    sync_seen = 1'b0;
  end
  // Odd start offset keeps link edges off the bus clock edges
  task automatic play(input int n);
    #0.3;
    repeat (n) begin
      sdi_pin = word_q[31 - bitn];
      #32;
      // Rise: a transmit word ends wherever a receive word starts
      if (bitn == 0) begin
        word_seen = {tx_sh[30:0], sdo};
        sync_seen = frame_sync;
      end
      tx_sh    = {tx_sh[30:0], sdo};
      bclk_pin = 1'b1;
      #32 bclk_pin = 1'b0;
      bitn = bitn + 1;
      if (bitn == 32) begin
        bitn   = 0;
        idx    = idx + 8'h01;
        word_q = {24'h5a5a5a, idx};
      end
    end
    // Released line shows the inverse, never a stale bit
    #40 sdi_pin = ~sdi_pin;
  endtask
endmodule

// ==== aufz_top_sva.sv ====
// Assertions on the bus side of the audio queue status block
`timescale 1ns/1ps
`include "aufz_defs.svh"
module aufz_top_sva #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_take;
  // Read taken at this edge; its word stands from the next cycle
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  sequence flags_rd;
    rd_take && haddr[7:0] == `AUFZ_OFS_FLAGS;
  endsequence
  sequence level_rd;
    rd_take && haddr[7:0] == `AUFZ_OFS_LEVELS;
  endsequence
  okay_only_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  no_wait_a: assert property ($past(hresetn) |-> hreadyout == 1'b1)
    else $error("wait state inserted");
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  int_or_a: assert property (flags_rd |=> hrdata[0] == (hrdata[1] | hrdata[2]))
    else $error("overall interrupt is not the OR");
  rx_int_a: assert property (flags_rd |=> !(hrdata[9] | hrdata[8]) || hrdata[1])
    else $error("receive event without receive interrupt");
  tx_int_a: assert property (flags_rd |=> !(hrdata[17] | hrdata[16]) || hrdata[2])
    else $error("transmit event without transmit interrupt");
  rx_ends_a: assert property (flags_rd |=> !(hrdata[12] && hrdata[11]))
    else $error("receive empty and full together");
  tx_ends_a: assert property (flags_rd |=> !(hrdata[20] && hrdata[19]))
    else $error("transmit empty and full together");
  level_range_a: assert property (level_rd |=> hrdata[20:16] <= DEPTH && hrdata[12:8] <= DEPTH)
    else $error("level above depth");
  flag_resv_a: assert property (flags_rd |=> hrdata[31:21] == 11'h0 && hrdata[15:13] == 3'h0)
    else $error("reserved flag bits set");
endmodule
bind aufz_top aufz_top_sva #(.DEPTH(DEPTH)) chk (
  .hclk      (hclk),
  .hresetn   (hresetn),
  .hsel      (hsel),
  .haddr     (haddr),
  .htrans    (htrans),
  .hwrite    (hwrite),
  .hready    (hready),
  .hrdata    (hrdata),
  .hreadyout (hreadyout),
  .hresp     (hresp)
);

// ==== test_audio_fifo_status_zero_cross.sv ====
// Self-checking bench for the audio queue status block
`timescale 1ns/1ps
`include "aufz_defs.svh"
module test_audio_fifo_status_zero_cross;
  // One scripted bus step and the masked value a read should show
  typedef struct packed {
    logic        wr;
    logic [7:0]  ofs;
    logic [31:0] wd;
    logic [31:0] mask;
    logic [31:0] want;
  } aufz_step_s;
  localparam logic [7:0] FL = `AUFZ_OFS_FLAGS;
  localparam logic [7:0] LV = `AUFZ_OFS_LEVELS;
  localparam logic [7:0] TX = `AUFZ_OFS_TXPORT;
  localparam logic [7:0] RX = `AUFZ_OFS_RXPORT;
  localparam logic [7:0] CT = `AUFZ_OFS_CTRL;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        bclk_pin, sdi_pin, sdo, frame_sync;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fails, n_compared;
  aufz_step_s  steps [17] = '{
    '{1'b0, FL, 32'h0, 32'h1f1f00, 32'h141000},
    '{1'b0, RX, 32'h0, 32'hffffffff, 32'h0},
    '{1'b0, FL, 32'h0, 32'h103, 32'h103},
    '{1'b1, FL, 32'h0, 32'h0, 32'h0},
    '{1'b0, FL, 32'h0, 32'h100, 32'h100},
    '{1'b1, LV, 32'hffffffff, 32'h0, 32'h0},
    '{1'b0, LV, 32'h0, 32'hffffffff, 32'h0},
    '{1'b1, FL, 32'h100, 32'h0, 32'h0},
    '{1'b0, FL, 32'h0, 32'h102, 32'h0},
    '{1'b1, CT, 32'h3, 32'h0, 32'h0},
    '{1'b1, TX, 32'h1111, 32'h0, 32'h0},
    '{1'b1, TX, 32'h80000001, 32'h0, 32'h0},
    '{1'b1, TX, 32'h2222, 32'h0, 32'h0},
    '{1'b0, FL, 32'h0, 32'h40000, 32'h40000},
    '{1'b1, TX, 32'h3333, 32'h0, 32'h0},
    '{1'b0, LV, 32'h0, 32'h1f00, 32'h400},
    '{1'b0, FL, 32'h0, 32'h1c0000, 32'h0}
  };
  aufz_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bclk_pin(bclk_pin), .sdi_pin(sdi_pin),
    .sdo(sdo), .frame_sync(frame_sync));
  aufz_codec codec (.bclk_pin(bclk_pin), .sdi_pin(sdi_pin), .sdo(sdo),
    .frame_sync(frame_sync));
  // Bus clock, 200 MHz
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;
  // Single transfer: address phase, then data phase, each until ready
  task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, ofs};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] mask, input logic [31:0] want);
    xfer(1'b0, ofs, 32'h0);
    n_compared++;
    if ((rd & mask) !== want) begin
      fails++;
      $display("MISMATCH reg %h expected %h seen %h", ofs, want, rd & mask);
    end
  endtask
  // Last whole word the codec took from the serial output, and its sync level
  task automatic link_chk(input logic [31:0] want_w, input logic want_s);
    n_compared++;
    if (codec.word_seen !== want_w || codec.sync_seen !== want_s) begin
      fails++;
      $display("MISMATCH link word/sync expected %h/%b seen %h/%b",
        want_w, want_s, codec.word_seen, codec.sync_seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs about 50 us
  initial begin
    #150000;
    fails++;
    give_verdict();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (steps[i]) begin
      if (steps[i].wr) begin
        xfer(1'b1, steps[i].ofs, steps[i].wd);
      end else begin
        rd_chk(steps[i].ofs, steps[i].mask, steps[i].want);
      end
    end
    // Fill to sixteen, one write too many is dropped
    for (int i = 0; i < 13; i++) begin
      xfer(1'b1, TX, 32'h100 + 32'(i));
    end
    rd_chk(FL, 32'he0000, 32'ha0000);
    rd_chk(LV, 32'h1f00, 32'h1000);
    xfer(1'b1, FL, 32'h20000);
    rd_chk(FL, 32'h20000, 32'h0);
    // Sixteen words each way; transmit drains exactly
    codec.play(512);
    link_chk(32'h0000_010a, 1'b1);
    rd_chk(FL, 32'h1f1f38, 32'h140c08);
    rd_chk(LV, 32'h1f1fff, 32'h100002);
    xfer(1'b1, LV, 32'hff);
    rd_chk(LV, 32'hff, 32'h0);
    // One more word: transmit runs dry, receive overflows
    codec.play(32);
    link_chk(32'h0000_0000, 1'b0);
    rd_chk(FL, 32'h10a00, 32'h10a00);
    for (int n = 1; n < 17; n++) begin
      rd_chk(RX, 32'hffffffff, {24'h5a5a5a, 8'(n)});
    end
    rd_chk(FL, 32'h1c00, 32'h1000);
    rd_chk(LV, 32'h1f0000, 32'h0);
    // Reset in mid-run, then eight-channel frames
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(FL, 32'h1f1f38, 32'h141000);
    xfer(1'b1, CT, 32'h700);
    for (int k = 0; k < 8; k++) begin
      codec.play(k == 0 ? 1 : 32);
      rd_chk(FL, 32'h10038, {15'h0, 1'b1, 10'h0, 3'(k), 3'h0});
      if (k == 1) begin
        link_chk(32'h0000_0000, 1'b1);
      end
    end
    give_verdict();
  end
endmodule
